// *** rtl/clock_synth_watchdog_ctrl.sv ***
// Purpose: Watchdog, M/N divisor, spread and ratio control of a clock synthesizer
// Assumes: Register requests arrive decoded from the serial-bus slave, one cycle wide
// Notes:   Read data is registered and valid the cycle after the read strobe
// Operation
// - Eight-bit watchdog period count, one unit per 250 ms.
// - Period count resets to eight, a two second timeout.
// - Running watchdog decrements the count by one each tick toward zero.
// - Reading the period count returns the live remaining count.
// - Feedback divisor is nine bits: MSB in bit 7, low byte next register.
// - Five-bit reference divisor in bits 4..0, reset to zero.
// - Spread rise count in upper nibble, reset 0001.
// - Spread fall count in lower nibble, reset 1111.
// - Select bit 0 uses frequency table, 1 uses M and N divisors.
// - Divisor mode VCO equals 14.318 MHz times (N+4) over M.
// - Watchdog expiry clears the direct divisor select bit.
// - After expiry run latched or safe code per fallback select.
// - Ratio select picks CPU, mid-rate and PCI divisors; 111 undefined.
// - Enable write starts or stops timer; read shows whether counting.
// - Expiry flag sets when count reaches zero, clears on restart.
// - Fallback 0 reloads latched straps, 1 reloads the safe code.
`timescale 1ns/10ps
`include "clock_synth_params.svh"
`default_nettype none

module clock_synth_watchdog_ctrl #(
  parameter int TICK_CYCLES = `WD_TICK_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire clock_synth_pkg::reg_req_t reg_req,
  input  wire logic [4:0]                strap_frequency_code,
  output logic [7:0]                     reg_rdata,
  output logic [4:0]                     active_frequency_code,
  output logic                           direct_divisor_select,
  output logic [8:0]                     feedback_divisor,
  output logic [4:0]                     ref_divisor,
  output logic [23:0]                    vco_target_khz_times_m,
  output logic [3:0]                     spread_rise_count,
  output logic [3:0]                     spread_fall_count,
  output clock_synth_pkg::ratio_t        ratio_divisors,
  output logic                           watchdog_expired_flag
);
  import clock_synth_pkg::*;

  wd_state_t   wd_q,        wd_d;
  logic [24:0] pre_q,       pre_d;
  logic        tick_q,      tick_d;
  logic [7:0]  count_q,     count_d;
  logic        expired_q,   expired_d;
  logic [4:0]  safe_q,      safe_d;
  logic        fallback_q,  fallback_d;
  logic        strap_q,     strap_d;
  logic [4:0]  freq_q,      freq_d;
  logic [4:0]  latched_q,   latched_d;
  logic        dsel_q,      dsel_d;
  logic [8:0]  fb_q,        fb_d;
  logic [4:0]  ref_q,       ref_d;
  logic        fhi_q,       fhi_d;
  logic        flo_q,       flo_d;
  logic [3:0]  rise_q,      rise_d;
  logic [3:0]  fall_q,      fall_d;
  logic [2:0]  rsel_q,      rsel_d;
  logic [2:0]  skew_q,      skew_d;
  ratio_t      ratio_q,     ratio_d;
  logic [23:0] vco_q,       vco_d;
  logic [7:0]  rdata_q,     rdata_d;
  logic        expire;
  logic        wr_hit;

  always_comb begin
    wr_hit = reg_req.wr;
    // Expiry on the tick that takes the count to zero, or on the next tick if it was already zero
    expire = (wd_q == WD_RUN) && tick_q && (count_q <= 8'h01);
    wd_d      = wd_q;
    pre_d     = pre_q;
    tick_d    = 1'b0;
    count_d   = count_q;
    expired_d = expired_q;
    safe_d    = safe_q;
    fallback_d = fallback_q;
    strap_d   = 1'b1;
    freq_d    = freq_q;
    latched_d = latched_q;
    dsel_d    = dsel_q;
    fb_d      = fb_q;
    ref_d     = ref_q;
    fhi_d     = fhi_q;
    flo_d     = flo_q;
    rise_d    = rise_q;
    fall_d    = fall_q;
    rsel_d    = rsel_q;
    skew_d    = skew_q;
    // Straps are caught one edge after reset release, never under reset itself
    if (!strap_q) begin
      freq_d    = strap_frequency_code;
      latched_d = strap_frequency_code;
    end
    if (wd_q == WD_RUN) begin
      if (pre_q == 25'(TICK_CYCLES - 1)) begin
        pre_d  = '0;
        tick_d = 1'b1;
      end else begin
        pre_d = pre_q + 25'h1;
      end
      if (tick_q && count_q != 8'h00) begin
        count_d = count_q - 8'h01;
      end
    end
    if (wr_hit) begin
      unique case (reg_req.addr)
        `OFS_FALLBACK_CFG: fallback_d = reg_req.wdata[0];
        `OFS_WD_CTRL: begin
          safe_d = reg_req.wdata[4:0];
          if (reg_req.wdata[`BIT_WD_ENABLE]) begin
            wd_d      = WD_RUN;
            pre_d     = '0;
            tick_d    = 1'b0;
            expired_d = 1'b0;
          end else begin
            wd_d = WD_IDLE;
          end
        end
        `OFS_WD_PERIOD: count_d = reg_req.wdata;
        `OFS_DIV_HIGH_REF: begin
          fb_d[8] = reg_req.wdata[`BIT_FB_DIV_MSB];
          fhi_d   = reg_req.wdata[`BIT_FACTORY_HIGH];
          flo_d   = reg_req.wdata[`BIT_FACTORY_LOW];
          ref_d   = reg_req.wdata[4:0];
        end
        `OFS_FB_DIV_LOW: fb_d[7:0] = reg_req.wdata;
        `OFS_SPREAD: begin
          rise_d = reg_req.wdata[7:4];
          fall_d = reg_req.wdata[3:0];
        end
        `OFS_MODE_RATIO: begin
          dsel_d = reg_req.wdata[`BIT_DIRECT_SEL];
          rsel_d = reg_req.wdata[5:3];
          skew_d = reg_req.wdata[2:0];
        end
        default: ;
      endcase
    end
    // Hardware expiry beats a same-cycle host write or restart
    if (expire) begin
      wd_d      = WD_IDLE;
      count_d   = 8'h00;
      expired_d = 1'b1;
      dsel_d    = 1'b0;
      // Pins may serve other uses after power-up, so the reset-time code is reloaded, or the safe code when fallback_q is set
      freq_d    = fallback_q ? safe_q : latched_q;
    end
  end

  always_comb begin
    // Code 111 has no defined ratio; all divisors read as zero there
    unique case (rsel_q)
      3'h0:    ratio_d = '{cpu: 4'h2, mid: 4'h4, pci: 4'h8};
      3'h1:    ratio_d = '{cpu: 4'h2, mid: 4'h5, pci: 4'ha};
      3'h2:    ratio_d = '{cpu: 4'h2, mid: 4'h6, pci: 4'hc};
      3'h3:    ratio_d = '{cpu: 4'h3, mid: 4'h6, pci: 4'hc};
      3'h4:    ratio_d = '{cpu: 4'h4, mid: 4'h4, pci: 4'h8};
      3'h5:    ratio_d = '{cpu: 4'h4, mid: 4'h6, pci: 4'hc};
      3'h6:    ratio_d = '{cpu: 4'h6, mid: 4'h6, pci: 4'hc};
      default: ratio_d = '{cpu: 4'h0, mid: 4'h0, pci: 4'h0};
    endcase
    // The divide by M is left to the synthesizer; this is the numerator in kHz
    vco_d = 24'(`REF_CLK_KHZ * (int'(fb_q) + `FB_DIV_OFFSET));
    rdata_d = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `OFS_FALLBACK_CFG: rdata_d = {7'h00, fallback_q};
        `OFS_WD_CTRL:      rdata_d = {1'b0, wd_q == WD_RUN, expired_q, safe_q};
        `OFS_WD_PERIOD:    rdata_d = count_q;
        `OFS_DIV_HIGH_REF: rdata_d = {fb_q[8], fhi_q, flo_q, ref_q};
        `OFS_FB_DIV_LOW:   rdata_d = fb_q[7:0];
        `OFS_SPREAD:       rdata_d = {rise_q, fall_q};
        `OFS_MODE_RATIO:   rdata_d = {dsel_q, 1'b0, rsel_q, skew_q};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_q       <= WD_IDLE;
      pre_q      <= '0;
      tick_q     <= 1'b0;
      count_q    <= `RST_WD_PERIOD;
      expired_q  <= 1'b0;
      safe_q     <= 5'h00;
      fallback_q <= 1'b0;
      strap_q    <= 1'b0;
      freq_q     <= 5'h00;
      latched_q  <= 5'h00;
      dsel_q     <= 1'b0;
      fb_q       <= 9'h000;
      ref_q      <= 5'h00;
      fhi_q      <= `RST_FACTORY_HIGH;
      flo_q      <= `RST_FACTORY_LOW;
      rise_q     <= `RST_SPREAD_RISE;
      fall_q     <= `RST_SPREAD_FALL;
      rsel_q     <= 3'h0;
      skew_q     <= `RST_SKEW;
      ratio_q    <= '{cpu: 4'h2, mid: 4'h4, pci: 4'h8};
      vco_q      <= 24'h000000;
      rdata_q    <= 8'h00;
    end else begin
      wd_q       <= wd_d;
      pre_q      <= pre_d;
      tick_q     <= tick_d;
      count_q    <= count_d;
      expired_q  <= expired_d;
      safe_q     <= safe_d;
      fallback_q <= fallback_d;
      strap_q    <= strap_d;
      freq_q     <= freq_d;
      latched_q  <= latched_d;
      dsel_q     <= dsel_d;
      fb_q       <= fb_d;
      ref_q      <= ref_d;
      fhi_q      <= fhi_d;
      flo_q      <= flo_d;
      rise_q     <= rise_d;
      fall_q     <= fall_d;
      rsel_q     <= rsel_d;
      skew_q     <= skew_d;
      ratio_q    <= ratio_d;
      vco_q      <= vco_d;
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata              = rdata_q;
  assign active_frequency_code  = freq_q;
  assign direct_divisor_select  = dsel_q;
  assign feedback_divisor       = fb_q;
  assign ref_divisor            = ref_q;
  assign vco_target_khz_times_m = vco_q;
  assign spread_rise_count      = rise_q;
  assign spread_fall_count      = fall_q;
  assign ratio_divisors         = ratio_q;
  assign watchdog_expired_flag  = expired_q;

  period_write_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.wr && reg_req.addr == `OFS_WD_PERIOD && !expire |=> count_q == $past(reg_req.wdata))
    else $error("period count did not take written value");
  count_down_a: assert property (@(posedge clk) disable iff (!nrst)
    wd_q == WD_RUN && tick_q && count_q > 8'h01 && !reg_req.wr
      |=> count_q == $past(count_q) - 8'h01)
    else $error("watchdog count did not step down by one");
  count_read_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.rd && reg_req.addr == `OFS_WD_PERIOD |=> reg_rdata == $past(count_q))
    else $error("period read did not return live count");
  fb_msb_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.wr && reg_req.addr == `OFS_DIV_HIGH_REF
      |=> feedback_divisor[8] == $past(reg_req.wdata[7]))
    else $error("feedback divisor msb wrong");
  expire_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    expire |=> !direct_divisor_select && watchdog_expired_flag && wd_q == WD_IDLE)
    else $error("expiry did not cancel divisor mode");
  fallback_code_a: assert property (@(posedge clk) disable iff (!nrst)
    expire |=> active_frequency_code == ($past(fallback_q) ? $past(safe_q) : $past(latched_q)))
    else $error("fallback frequency code wrong");
  restart_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.wr && reg_req.addr == `OFS_WD_CTRL && reg_req.wdata[6] && !expire
      |=> !watchdog_expired_flag)
    else $error("restart did not clear expiry flag");
  enable_read_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.rd && reg_req.addr == `OFS_WD_CTRL |=> reg_rdata[6] == $past(wd_q == WD_RUN))
    else $error("enable readback does not show counting state");
  ratio_table_a: assert property (@(posedge clk) disable iff (!nrst)
    rsel_q == 3'h3 |=> ratio_divisors == '{cpu: 4'h3, mid: 4'h6, pci: 4'hc})
    else $error("ratio select 011 gave wrong divisors");
  spread_write_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.wr && reg_req.addr == `OFS_SPREAD
      |=> {spread_rise_count, spread_fall_count} == $past(reg_req.wdata))
    else $error("spread counts not written");
  tick_space_a: assert property (@(posedge clk) disable iff (!nrst)
    tick_q |=> !tick_q)
    else $error("tick lasted more than one cycle");

  expire_seen_c: cover property (@(posedge clk) disable iff (!nrst) expire);
  safe_reload_c: cover property (@(posedge clk) disable iff (!nrst) expire && fallback_q);
  restart_c: cover property (@(posedge clk) disable iff (!nrst)
    watchdog_expired_flag ##1 !watchdog_expired_flag);
  count_step_c: cover property (@(posedge clk) disable iff (!nrst) tick_q && count_q > 8'h01);
  mn_mode_c: cover property (@(posedge clk) disable iff (!nrst)
    direct_divisor_select && wd_q == WD_RUN);

  ref_write_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.wr && reg_req.addr == `OFS_DIV_HIGH_REF |=> ref_divisor == $past(reg_req.wdata[4:0]))
    else $error("reference divisor not written");
  dsel_write_a: assert property (@(posedge clk) disable iff (!nrst)
    reg_req.wr && reg_req.addr == `OFS_MODE_RATIO && !expire
      |=> direct_divisor_select == $past(reg_req.wdata[`BIT_DIRECT_SEL]))
    else $error("divisor select not written");
  idle_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    wd_q == WD_IDLE && !(reg_req.wr && reg_req.addr == `OFS_WD_PERIOD)
      |=> count_q == $past(count_q))
    else $error("stopped watchdog changed its count");
  expire_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    expire |=> count_q == 8'h00)
    else $error("expiry did not leave the count at zero");
  strap_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    !strap_q |=> active_frequency_code == $past(strap_frequency_code)
      && latched_q == active_frequency_code)
    else $error("straps not latched after reset");

endmodule : clock_synth_watchdog_ctrl

`default_nettype wire

// *** rtl/clock_synth_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz core clock
// Notes:   Byte-wide register file reached through the serial-bus front end
`ifndef CLOCK_SYNTH_PARAMS_SVH
`define CLOCK_SYNTH_PARAMS_SVH

`define OFS_FALLBACK_CFG      8'h00
`define OFS_WD_CTRL           8'h05
`define OFS_WD_PERIOD         8'h06
`define OFS_DIV_HIGH_REF      8'h07
`define OFS_FB_DIV_LOW        8'h08
`define OFS_SPREAD            8'h09
`define OFS_MODE_RATIO        8'h0a

`define BIT_WD_ENABLE         6
`define BIT_WD_EXPIRED        5
`define BIT_FB_DIV_MSB        7
`define BIT_FACTORY_HIGH      6
`define BIT_FACTORY_LOW       5
`define BIT_DIRECT_SEL        7

`define RST_WD_PERIOD         8'h08
`define RST_FACTORY_HIGH      1'b1
`define RST_FACTORY_LOW       1'b0
`define RST_SPREAD_RISE       4'h1
`define RST_SPREAD_FALL       4'hf
`define RST_SKEW              3'h4

`define REF_CLK_KHZ           14318
`define FB_DIV_OFFSET         4
`define CLK_PERIOD_NS         10
`define WD_TICK_MS            250
`define WD_TICK_CYCLES        ((`WD_TICK_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// *** rtl/clock_synth_pkg.sv ***
// Purpose: Types shared by the clock synthesizer control logic
// Assumes: Byte-wide register access
// Notes:   Offsets and counts live in clock_synth_params.svh
package clock_synth_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] cpu;
    logic [3:0] mid;
    logic [3:0] pci;
  } ratio_t;

  typedef enum logic {
    WD_IDLE = 1'b0,
    WD_RUN  = 1'b1
  } wd_state_t;

endpackage : clock_synth_pkg

// *** verification/host_model.sv ***
// Purpose: Host side of the register port, one request per task call
// Assumes: Requests launched at the falling edge, taken at the next rising edge
// Notes:   Writes to the divisor register keep the factory bits at one and zero
`timescale 1ns/10ps
`include "clock_synth_params.svh"
`default_nettype none

module host_model (
  input  wire logic                      clk,
  output var  clock_synth_pkg::reg_req_t reg_req,
  input  wire logic [7:0]                reg_rdata
);
  import clock_synth_pkg::*;

  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req_t r;
    r = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    // Factory bits are never changed, whatever the caller passes
    if (a == `OFS_DIV_HIGH_REF) r.wdata[6:5] = 2'b10;
    @(negedge clk);
    reg_req = r;
    @(negedge clk);
    reg_req = '0;
  endtask : wr

  // Read data stands one cycle only, so it is taken at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    reg_req = '0;
    d = reg_rdata;
  endtask : rd
endmodule : host_model

`default_nettype wire

// *** verification/clock_synth_watchdog_ctrl_test.sv ***
// Purpose: Self-checking bench for the clock synthesizer control block
// Assumes: Short watchdog tick so a timeout fits in a few dozen cycles
// Notes:   Register traffic goes through host_model
`timescale 1ns/10ps
`include "clock_synth_params.svh"
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end

module clock_synth_watchdog_ctrl_test;
  import clock_synth_pkg::*;
  localparam int TICK = 8;
  typedef struct packed {logic w; logic [7:0] a, d, e;} row_t;
  logic        clk   = 1'b0;
  logic        nrst  = 1'b0;
  logic [4:0]  strap = 5'h16;
  reg_req_t    req;
  logic [7:0]  rdata, got;
  logic [4:0]  freq, mdiv;
  logic        dsel, expd;
  logic [8:0]  ndiv;
  logic [23:0] vco;
  logic [3:0]  rise, fall;
  ratio_t      ratio;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          n;
  row_t rows[10] = '{'{1'b0, 8'h06, 8'h00, 8'h08}, '{1'b0, 8'h07, 8'h00, 8'h40},
                     '{1'b0, 8'h09, 8'h00, 8'h1f}, '{1'b0, 8'h0a, 8'h00, 8'h04},
                     '{1'b0, 8'h03, 8'h00, 8'h00}, '{1'b1, 8'h06, 8'h03, 8'h03},
                     '{1'b1, 8'h07, 8'h95, 8'hd5}, '{1'b1, 8'h08, 8'h23, 8'h23},
                     '{1'b1, 8'h09, 8'ha5, 8'ha5}, '{1'b1, 8'h03, 8'hff, 8'h00}};
  logic [11:0] rt[8] = '{12'h248, 12'h25a, 12'h26c, 12'h36c,
                         12'h448, 12'h46c, 12'h66c, 12'h000};

  always #5 clk = ~clk;

  clock_synth_watchdog_ctrl #(.TICK_CYCLES(TICK)) u_clock_synth_watchdog_ctrl (
    .clk(clk), .nrst(nrst), .reg_req(req), .strap_frequency_code(strap),
    .reg_rdata(rdata), .active_frequency_code(freq), .direct_divisor_select(dsel),
    .feedback_divisor(ndiv), .ref_divisor(mdiv), .vco_target_khz_times_m(vco),
    .spread_rise_count(rise), .spread_fall_count(fall), .ratio_divisors(ratio),
    .watchdog_expired_flag(expd));

  host_model u_host_model (.clk(clk), .reg_req(req), .reg_rdata(rdata));

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(a, got);
    `CHK("rdata", e, got)
  endtask : rchk

  // Bounded so a flag that never rises cannot hang the run
  task automatic wait_exp;
    n = 0;
    while (expd !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_exp

  task automatic end_of_test;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (5) @(negedge clk);
    `CHK("ratio", 12'h248, ratio)
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("freq", strap, freq)
    foreach (rows[i]) begin
      if (rows[i].w) u_host_model.wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    `CHK("ndiv", 9'h123, ndiv)
    `CHK("mdiv", 5'h15, mdiv)
    `CHK("vco", 24'(`REF_CLK_KHZ * (9'h123 + `FB_DIV_OFFSET)), vco)
    `CHK("rise", 4'ha, rise)
    `CHK("fall", 4'h5, fall)
    for (int s = 0; s < 8; s++) begin
      u_host_model.wr(`OFS_MODE_RATIO, {2'b00, 3'(s), 3'h4});
      @(negedge clk);
      `CHK("ratio", rt[s], ratio)
    end
    u_host_model.wr(`OFS_MODE_RATIO, 8'h84);
    `CHK("dsel", 1'b1, dsel)
    rchk(`OFS_MODE_RATIO, 8'h84);
    // A stopped timer keeps its remaining count
    u_host_model.wr(`OFS_WD_PERIOD, 8'h05);
    u_host_model.wr(`OFS_WD_CTRL, 8'h40);
    rchk(`OFS_WD_CTRL, 8'h40);
    u_host_model.wr(`OFS_WD_CTRL, 8'h00);
    repeat (3 * TICK) @(negedge clk);
    rchk(`OFS_WD_PERIOD, 8'h05);
    `CHK("expd", 1'b0, expd)
    // Expiry falls back to the safe code
    u_host_model.wr(`OFS_FALLBACK_CFG, 8'h01);
    u_host_model.wr(`OFS_WD_PERIOD, 8'h02);
    u_host_model.wr(`OFS_WD_CTRL, 8'h4b);
    wait_exp();
    `CHK("expiry cycles", 2 * TICK + 1, n)
    `CHK("dsel", 1'b0, dsel)
    `CHK("freq", 5'h0b, freq)
    rchk(`OFS_WD_PERIOD, 8'h00);
    rchk(`OFS_WD_CTRL, 8'h2b);
    // Restart clears the flag; expiry now reloads the straps latched at reset,
    // so the pins move first to show that their live value is not used
    strap = 5'h09;
    u_host_model.wr(`OFS_MODE_RATIO, 8'h84);
    u_host_model.wr(`OFS_FALLBACK_CFG, 8'h00);
    u_host_model.wr(`OFS_WD_PERIOD, 8'h01);
    u_host_model.wr(`OFS_WD_CTRL, 8'h40);
    `CHK("expd", 1'b0, expd)
    wait_exp();
    `CHK("expiry cycles", TICK + 1, n)
    `CHK("freq", 5'h16, freq)
    `CHK("dsel", 1'b0, dsel)
    // Reset in mid-run: defaults return and the straps are latched afresh
    nrst = 1'b0;
    @(negedge clk);
    `CHK("freq", 5'h00, freq)
    `CHK("expd", 1'b0, expd)
    nrst = 1'b1;
    @(negedge clk);
    `CHK("freq", 5'h09, freq)
    rchk(`OFS_WD_PERIOD, `RST_WD_PERIOD);
    end_of_test();
  end
endmodule : clock_synth_watchdog_ctrl_test

`default_nettype wire
